// ===== hw/ltd_pkg.sv
// package: register map, field layout and encodings of the logic tile datapath
package ltd_pkg;
	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int unsigned DATA_W     = 8;
	localparam int unsigned CRAM_WORDS = 8;
	localparam int unsigned CRAM_W     = 16;
	localparam int unsigned FIFO_DEPTH = 4;
	localparam int unsigned COND_W     = 16;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_ACC0  = 8'h00;
	localparam logic [7:0] OFF_ACC1  = 8'h04;
	localparam logic [7:0] OFF_DAT0  = 8'h08;
	localparam logic [7:0] OFF_DAT1  = 8'h0C;
	localparam logic [7:0] OFF_FIFO0 = 8'h10;
	localparam logic [7:0] OFF_FIFO1 = 8'h14;
	localparam logic [7:0] OFF_CTRL  = 8'h18;
	localparam logic [7:0] OFF_STAT  = 8'h1C;
	localparam logic [7:0] OFF_CFG   = 8'h20;
	localparam logic [7:0] OFF_MASK  = 8'h24;
	localparam logic [7:0] OFF_OSEL  = 8'h28;
	localparam logic [7:0] OFF_SSEL  = 8'h2C;
	localparam logic [7:0] OFF_CRAM  = 8'h40;
	localparam logic [7:0] OFF_CRAM_LAST = 8'h5C;

	// ----------------------------------------
	// static configuration fields
	// ----------------------------------------
	localparam int unsigned CFG_DP_EN  = 0;
	localparam int unsigned CFG_SC_EN  = 1;
	localparam int unsigned CFG_F0_OUT = 2;
	localparam int unsigned CFG_MSB    = 4;
	localparam int unsigned CFG_CHAIN  = 7;
	localparam int unsigned CFG_TMUX   = 8;
	localparam int unsigned MSK_CMP0   = 0;
	localparam int unsigned MSK_CMP1   = 8;
	localparam int unsigned MSK_OR     = 16;
	localparam int unsigned MSK_STICKY = 24;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [31:0] CFG_RST  = 32'h0000_0070;
	localparam logic [31:0] MASK_RST = 32'h0000_FFFF;
	localparam logic [31:0] SEL_RST  = 32'h0000_0000;

	// ----------------------------------------
	// per-cycle configuration word fields
	// ----------------------------------------
	localparam int unsigned CW_OP   = 0;
	localparam int unsigned CW_SRCA = 3;
	localparam int unsigned CW_SRCB = 4;
	localparam int unsigned CW_SHF  = 6;
	localparam int unsigned CW_DST  = 8;
	localparam int unsigned CW_ORM  = 10;
	localparam int unsigned CW_CIN  = 11;
	localparam int unsigned CW_CRC  = 12;
	localparam int unsigned CW_CMP  = 13;
	localparam int unsigned CW_F0   = 14;

	typedef enum logic [2:0] {
		OP_PASS = 3'h0,
		OP_INC  = 3'h1,
		OP_DEC  = 3'h2,
		OP_ADD  = 3'h3,
		OP_SUB  = 3'h4,
		OP_AND  = 3'h5,
		OP_OR   = 3'h6,
		OP_XOR  = 3'h7
	} ltd_alu_op_t;

	typedef enum logic [1:0] {
		SH_NONE  = 2'h0,
		SH_LEFT  = 2'h1,
		SH_RIGHT = 2'h2,
		SH_SWAP  = 2'h3
	} ltd_shift_t;
endpackage : ltd_pkg

// ===== hw/ltd_fifo.sv
// four-byte buffer between the bus side and the datapath side
`timescale 1ns/1ps
module ltd_fifo #(
	parameter int unsigned W     = 8,
	parameter int unsigned DEPTH = 4
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// filling side
	input  wire logic         push,
	input  wire logic [W-1:0] wdata,
	// draining side
	input  wire logic         pop,
	output logic      [W-1:0] rdata,
	// state
	output logic              full,
	output logic              empty
);
	localparam int unsigned PW = $clog2(DEPTH);
	localparam int unsigned CW = $clog2(DEPTH + 1);

	logic [W-1:0]  mem_ff [DEPTH];
	logic [W-1:0]  last_ff;
	logic [PW-1:0] wptr_ff;
	logic [PW-1:0] rptr_ff;
	logic [CW-1:0] count_ff;
	logic          do_push;
	logic          do_pop;

	// depth must be a power of two: pointers wrap by overflow
	assign full    = (count_ff == CW'(DEPTH));
	assign empty   = (count_ff == '0);
	assign do_push = push & ~full;
	assign do_pop  = pop & ~empty;
	// empty read returns the last value taken
	assign rdata   = empty ? last_ff : mem_ff[rptr_ff];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr_ff  <= '0;
			rptr_ff  <= '0;
			count_ff <= '0;
			last_ff  <= '0;
		end else begin
			if (do_push) begin
				wptr_ff <= PW'(wptr_ff + 1'b1);
			end
			if (do_pop) begin
				rptr_ff <= PW'(rptr_ff + 1'b1);
				last_ff <= mem_ff[rptr_ff];
			end
			count_ff <= CW'(count_ff + CW'(do_push) - CW'(do_pop));
		end
	end

	always_ff @(posedge pclk) begin
		if (do_push) begin
			mem_ff[wptr_ff] <= wdata;
		end
	end

	property p_full_drop;
		@(posedge pclk) disable iff (!presetn)
		push && full && !pop |=> full && $stable(wptr_ff);
	endproperty
	a_full_drop: assert property (p_full_drop) else $error("write into full buffer stored");

	property p_empty_hold;
		@(posedge pclk) disable iff (!presetn)
		pop && empty && !push |=> empty && rdata == $past(rdata);
	endproperty
	a_empty_hold: assert property (p_empty_hold) else $error("empty read moved");
endmodule : ltd_fifo

// ===== hw/ltd_datapath.sv
// logic tile datapath with control and status registers behind an apb slave
`timescale 1ns/1ps
module ltd_datapath #(
	parameter int unsigned FIFO_DEPTH = ltd_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// routing fabric
	input  wire logic [5:0]  route_in,
	output logic      [5:0]  route_out,
	output logic      [7:0]  ctrl_out,
	// chaining
	input  wire logic        chain_carry_in,
	input  wire logic        chain_shift_in,
	input  wire logic        chain_eq_in,
	input  wire logic        chain_lt_in,
	output logic             chain_carry_out,
	output logic             chain_shift_out,
	output logic             chain_eq_out,
	output logic             chain_lt_out
);
	logic [31:0] cfg_ff, mask_ff, osel_ff, ssel_ff, prdata_ff, nxt_prdata;
	logic [7:0]  acc0_ff, acc1_ff, dat0_ff, dat1_ff, ctrl_ff, sticky_ff;
	logic [15:0] cram_ff [ltd_pkg::CRAM_WORDS];
	logic [15:0] cw;
	logic [7:0]  src_a, src_b, b_eff, alu, post, result, wmask;
	logic [7:0]  c0a, c0b, c1a, c1b, stat_raw, stat_val;
	logic [8:0]  sum9;
	logic [2:0]  msb;
	logic [15:0] cond;
	logic [5:0]  route_out_ff;
	logic [3:0]  chain_ff;
	logic        carry_ff, shift_ff, pready_ff, pslverr_ff;
	logic        setup, done, wr, rd, dp_run, sc_run, chain_en, tmux;
	logic        si, ci, co, so, ov, fb, eq0, lt0, eq1, lt1;
	logic [1:0]  f_push, f_pop, f_full, f_empty, f_load;
	logic [7:0]  f_wdata [2];
	logic [7:0]  f_rdata [2];
	ltd_pkg::ltd_alu_op_t op;

	function automatic logic addr_ok(input logic [7:0] a);
		return (a[1:0] == 2'h0) && ((a <= ltd_pkg::OFF_SSEL) ||
			((a >= ltd_pkg::OFF_CRAM) && (a <= ltd_pkg::OFF_CRAM_LAST)));
	endfunction : addr_ok

	function automatic logic in_cram(input logic [7:0] a);
		return (a >= ltd_pkg::OFF_CRAM) && (a <= ltd_pkg::OFF_CRAM_LAST);
	endfunction : in_cram

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	// no wait state: read data is sampled in setup so outputs stay registered
	assign setup = psel & ~penable;
	assign done  = psel & penable & pready_ff;
	assign wr    = done & pwrite & ~pslverr_ff;
	assign rd    = done & ~pwrite & ~pslverr_ff;

	always_comb begin
		nxt_prdata = 32'h0000_0000;
		unique case (paddr)
			ltd_pkg::OFF_ACC0:  nxt_prdata[7:0] = acc0_ff;
			ltd_pkg::OFF_ACC1:  nxt_prdata[7:0] = acc1_ff;
			ltd_pkg::OFF_DAT0:  nxt_prdata[7:0] = dat0_ff;
			ltd_pkg::OFF_DAT1:  nxt_prdata[7:0] = dat1_ff;
			ltd_pkg::OFF_FIFO0: nxt_prdata[7:0] = f_rdata[0];
			ltd_pkg::OFF_FIFO1: nxt_prdata[7:0] = f_rdata[1];
			ltd_pkg::OFF_CTRL:  nxt_prdata[7:0] = ctrl_ff;
			ltd_pkg::OFF_STAT:  nxt_prdata[7:0] = stat_val;
			ltd_pkg::OFF_CFG:   nxt_prdata = cfg_ff;
			ltd_pkg::OFF_MASK:  nxt_prdata = mask_ff;
			ltd_pkg::OFF_OSEL:  nxt_prdata = osel_ff;
			ltd_pkg::OFF_SSEL:  nxt_prdata = ssel_ff;
			default: begin
				if (in_cram(paddr)) begin
					nxt_prdata[15:0] = cram_ff[paddr[4:2]];
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			pready_ff  <= setup;
			pslverr_ff <= setup & ~addr_ok(paddr);
			if (setup) begin
				prdata_ff <= nxt_prdata;
			end
		end
	end

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff  <= ltd_pkg::CFG_RST;
			mask_ff <= ltd_pkg::MASK_RST;
			osel_ff <= ltd_pkg::SEL_RST;
			ssel_ff <= ltd_pkg::SEL_RST;
			ctrl_ff <= 8'h00;
		end else if (wr) begin
			if (paddr == ltd_pkg::OFF_CFG)  cfg_ff  <= pwdata;
			if (paddr == ltd_pkg::OFF_MASK) mask_ff <= pwdata;
			if (paddr == ltd_pkg::OFF_OSEL) osel_ff <= pwdata;
			if (paddr == ltd_pkg::OFF_SSEL) ssel_ff <= pwdata;
			if (paddr == ltd_pkg::OFF_CTRL) ctrl_ff <= pwdata[7:0];
		end
	end

	// configuration memory, written only over the bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < ltd_pkg::CRAM_WORDS; i++) begin
				cram_ff[i] <= 16'h0000;
			end
		end else if (wr && in_cram(paddr)) begin
			cram_ff[paddr[4:2]] <= pwdata[15:0];
		end
	end

	// ----------------------------------------
	// operand and alu
	// ----------------------------------------
	assign dp_run   = cfg_ff[ltd_pkg::CFG_DP_EN];
	assign sc_run   = cfg_ff[ltd_pkg::CFG_SC_EN];
	assign chain_en = cfg_ff[ltd_pkg::CFG_CHAIN];
	assign tmux     = cfg_ff[ltd_pkg::CFG_TMUX];
	assign msb      = cfg_ff[ltd_pkg::CFG_MSB +: 3];
	assign wmask    = 8'hFF >> (3'h7 - msb);
	assign cw       = cram_ff[route_in[2:0]];
	assign op       = ltd_pkg::ltd_alu_op_t'(cw[ltd_pkg::CW_OP +: 3]);
	assign src_a    = cw[ltd_pkg::CW_SRCA] ? acc1_ff : acc0_ff;
	// registered carry and shift win over live neighbours when time sharing
	assign si = tmux ? shift_ff : (chain_en ? chain_shift_in : route_in[3]);
	assign ci = cw[ltd_pkg::CW_CIN] &
		(tmux ? carry_ff : (chain_en ? chain_carry_in : route_in[4]));

	always_comb begin
		unique case (cw[ltd_pkg::CW_SRCB +: 2])
			2'h0: src_b = dat0_ff;
			2'h1: src_b = dat1_ff;
			2'h2: src_b = acc0_ff;
			2'h3: src_b = acc1_ff;
		endcase
	end

	always_comb begin
		unique case (op)
			ltd_pkg::OP_PASS: sum9 = {1'b0, src_a};
			ltd_pkg::OP_INC:  sum9 = {1'b0, src_a} + 9'h001;
			ltd_pkg::OP_DEC:  sum9 = {1'b0, src_a} - 9'h001;
			ltd_pkg::OP_ADD:  sum9 = {1'b0, src_a} + {1'b0, src_b} + {8'h00, ci};
			ltd_pkg::OP_SUB:  sum9 = {1'b0, src_a} - {1'b0, src_b} - {8'h00, ci};
			ltd_pkg::OP_AND:  sum9 = {1'b0, src_a & src_b};
			ltd_pkg::OP_OR:   sum9 = {1'b0, src_a | src_b};
			ltd_pkg::OP_XOR:  sum9 = {1'b0, src_a ^ src_b};
		endcase
	end

	assign b_eff = (op == ltd_pkg::OP_SUB) ? ~src_b : src_b;
	assign co    = sum9[4'(msb) + 4'h1];
	assign ov    = ((op == ltd_pkg::OP_ADD) || (op == ltd_pkg::OP_SUB)) &&
		(src_a[msb] == b_eff[msb]) && (sum9[msb] != src_a[msb]);
	assign fb    = src_a[msb] ^ si;
	assign alu   = sum9[7:0];

	// ----------------------------------------
	// post stage
	// ----------------------------------------
	always_comb begin
		post = alu;
		so   = 1'b0;
		unique case (ltd_pkg::ltd_shift_t'(cw[ltd_pkg::CW_SHF +: 2]))
			ltd_pkg::SH_NONE:  post = alu;
			ltd_pkg::SH_LEFT: begin
				post = {alu[6:0], si};
				so   = alu[msb];
			end
			ltd_pkg::SH_RIGHT: begin
				post = ((alu >> 1) & ~(8'h01 << msb)) | ({7'h00, si} << msb);
				so   = alu[0];
			end
			ltd_pkg::SH_SWAP:  post = {alu[3:0], alu[7:4]};
		endcase
		// polynomial taken from operand b, feedback from the msb
		if (cw[ltd_pkg::CW_CRC]) begin
			post = {src_a[6:0], 1'b0} ^ (fb ? src_b : 8'h00);
			so   = src_a[msb];
		end
		if (cw[ltd_pkg::CW_ORM]) begin
			post = post | mask_ff[ltd_pkg::MSK_OR +: 8];
		end
		result = post & wmask;
	end

	// ----------------------------------------
	// conditions
	// ----------------------------------------
	assign c0a = acc0_ff & mask_ff[ltd_pkg::MSK_CMP0 +: 8];
	assign c0b = (cw[ltd_pkg::CW_CMP] ? acc1_ff : dat0_ff) & mask_ff[ltd_pkg::MSK_CMP0 +: 8];
	assign c1a = (cw[ltd_pkg::CW_CMP] ? acc0_ff : acc1_ff) & mask_ff[ltd_pkg::MSK_CMP1 +: 8];
	assign c1b = dat1_ff & mask_ff[ltd_pkg::MSK_CMP1 +: 8];
	// this tile is the upper byte; the lower neighbour decides ties
	assign eq0 = (c0a == c0b) & (~chain_en | chain_eq_in);
	assign lt0 = (c0a < c0b) | ((c0a == c0b) & chain_en & chain_lt_in);
	assign eq1 = (c1a == c1b);
	assign lt1 = (c1a < c1b);
	assign cond = {route_in[5], f_full[1], f_empty[1], f_full[0], f_empty[0], so, co, ov,
		acc1_ff == 8'hFF, acc0_ff == 8'hFF, acc1_ff == 8'h00, acc0_ff == 8'h00,
		lt1, eq1, lt0, eq0};

	// ----------------------------------------
	// buffers
	// ----------------------------------------
	for (genvar i = 0; i < 2; i++) begin : g_fifo
		localparam logic [7:0] OFF = ltd_pkg::OFF_FIFO0 + 8'(4 * i);
		logic out_mode;
		logic dp_side;
		assign out_mode   = cfg_ff[ltd_pkg::CFG_F0_OUT + i];
		assign dp_side    = dp_run & cw[ltd_pkg::CW_F0 + i];
		assign f_push[i]  = out_mode ? dp_side : (wr && paddr == OFF);
		assign f_pop[i]   = out_mode ? (rd && paddr == OFF) : dp_side;
		assign f_load[i]  = dp_side & ~out_mode;
		assign f_wdata[i] = out_mode ? result : pwdata[7:0];
		ltd_fifo #(
			.W     (ltd_pkg::DATA_W),
			.DEPTH (FIFO_DEPTH)
		) u_fifo (
			.pclk    (pclk),
			.presetn (presetn),
			.push    (f_push[i]),
			.wdata   (f_wdata[i]),
			.pop     (f_pop[i]),
			.rdata   (f_rdata[i]),
			.full    (f_full[i]),
			.empty   (f_empty[i])
		);
	end

	// ----------------------------------------
	// working registers
	// ----------------------------------------
	// a bus write wins over the datapath in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc0_ff  <= 8'h00;
			acc1_ff  <= 8'h00;
			dat0_ff  <= 8'h00;
			dat1_ff  <= 8'h00;
			carry_ff <= 1'b0;
			shift_ff <= 1'b0;
		end else begin
			if (wr && paddr == ltd_pkg::OFF_ACC0) acc0_ff <= pwdata[7:0];
			else if (dp_run && cw[ltd_pkg::CW_DST]) acc0_ff <= result;
			if (wr && paddr == ltd_pkg::OFF_ACC1) acc1_ff <= pwdata[7:0];
			else if (dp_run && cw[ltd_pkg::CW_DST + 1]) acc1_ff <= result;
			if (wr && paddr == ltd_pkg::OFF_DAT0) dat0_ff <= pwdata[7:0];
			else if (f_load[0]) dat0_ff <= f_rdata[0];
			if (wr && paddr == ltd_pkg::OFF_DAT1) dat1_ff <= pwdata[7:0];
			else if (f_load[1]) dat1_ff <= f_rdata[1];
			if (dp_run) begin
				carry_ff <= co;
				shift_ff <= so;
			end
		end
	end

	// ----------------------------------------
	// status capture
	// ----------------------------------------
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			stat_raw[i] = cond[ssel_ff[4 * i +: 4]];
		end
		stat_val = (mask_ff[ltd_pkg::MSK_STICKY +: 8] & sticky_ff) |
			(~mask_ff[ltd_pkg::MSK_STICKY +: 8] & stat_raw);
	end

	// only bits that were returned are cleared; a new set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sticky_ff <= 8'h00;
		end else if (sc_run) begin
			sticky_ff <= (stat_raw & mask_ff[ltd_pkg::MSK_STICKY +: 8]) |
				(sticky_ff & ~((rd && paddr == ltd_pkg::OFF_STAT) ? prdata_ff[7:0] : 8'h00));
		end
	end

	// ----------------------------------------
	// routing and chain outputs
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			route_out_ff <= 6'h00;
			chain_ff     <= 4'h0;
		end else begin
			for (int i = 0; i < 6; i++) begin
				route_out_ff[i] <= cond[osel_ff[4 * i +: 4]];
			end
			chain_ff <= {lt0, eq0, so, co};
		end
	end

	assign prdata          = prdata_ff;
	assign pready          = pready_ff;
	assign pslverr         = pslverr_ff;
	assign route_out       = route_out_ff;
	assign ctrl_out        = ctrl_ff;
	assign chain_carry_out = chain_ff[0];
	assign chain_shift_out = chain_ff[1];
	assign chain_eq_out    = chain_ff[2];
	assign chain_lt_out    = chain_ff[3];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_cram_write;
		wr && in_cram(paddr) |=> cram_ff[$past(paddr[4:2])] == $past(pwdata[15:0]);
	endproperty
	a_cram_write: assert property (p_cram_write) else $error("config word not stored");

	property p_ctrl_out;
		wr && paddr == ltd_pkg::OFF_CTRL |=> ctrl_out == $past(pwdata[7:0]);
	endproperty
	a_ctrl_out: assert property (p_ctrl_out) else $error("control bits not driven");

	property p_inc;
		dp_run && op == ltd_pkg::OP_INC && cw[9:8] == 2'h1 && !cw[ltd_pkg::CW_SRCA] &&
		cw[7:6] == 2'h0 && cw[12:10] == 3'h0 && msb == 3'h7 && !wr
		|=> acc0_ff == 8'($past(acc0_ff) + 8'h01);
	endproperty
	a_inc: assert property (p_inc) else $error("increment wrong");

	property p_idle;
		!dp_run && !wr |=> $stable(acc0_ff) && $stable(acc1_ff);
	endproperty
	a_idle: assert property (p_idle) else $error("datapath ran while disabled");

	property p_tmux_carry;
		dp_run ##1 dp_run && tmux && cw[ltd_pkg::CW_CIN] |-> ci == $past(co);
	endproperty
	a_tmux_carry: assert property (p_tmux_carry) else $error("registered carry lost");

	property p_sticky_hold;
		sc_run && sticky_ff[0] && !(rd && paddr == ltd_pkg::OFF_STAT) |=> sticky_ff[0];
	endproperty
	a_sticky_hold: assert property (p_sticky_hold) else $error("held status dropped");

	property p_sticky_clear;
		sc_run && rd && paddr == ltd_pkg::OFF_STAT && prdata_ff[0] && !stat_raw[0]
		|=> !sticky_ff[0];
	endproperty
	a_sticky_clear: assert property (p_sticky_clear) else $error("read did not clear");

	property p_route_sel;
		osel_ff[3:0] == 4'hB ##1 osel_ff[3:0] == 4'hB |-> route_out[0] == $past(f_empty[0]);
	endproperty
	a_route_sel: assert property (p_route_sel) else $error("buffer flag not routed");
endmodule : ltd_datapath

// ===== verif/ltd_route_model.sv
// routing fabric model: word select, spare condition and chain inputs
`timescale 1ns/1ps
module ltd_route_model (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// requests from the bench
	input  wire logic [2:0] idx_req,
	input  wire logic       spare_req,
	input  wire logic       ser_req,
	// toward the tile
	output logic      [5:0] route_in,
	output logic      [3:0] chain_in
);
	// ----------------------------------------
	// fabric registers
	// ----------------------------------------
	// chain lines churn every cycle so an unused chain never looks quiet
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			route_in <= 6'h00;
			chain_in <= 4'h0;
		end else begin
			route_in <= {spare_req, 1'b0, ser_req, idx_req};
			chain_in <= 4'($urandom);
		end
	end
endmodule : ltd_route_model

// ===== verif/ltd_datapath_tb_top.sv
// self-checking bench of the logic tile datapath
`timescale 1ns/1ps
module ltd_datapath_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, spare_req;
	logic [7:0]  paddr, ctrl_out, m;
	logic [31:0] pwdata, prdata, r, d, a, b, first;
	logic [5:0]  route_in, route_out;
	logic [3:0]  chain_in;
	logic [2:0]  idx_req;
	logic [15:0] cw;
	logic        e, s, ser_req;
	logic [8:0]  c9;
	logic [3:0]  chain_out;
	int          err_total, cmp_count, cyc;
	ltd_route_model fab_u (.pclk(pclk), .presetn(presetn), .idx_req(idx_req),
		.spare_req(spare_req), .ser_req(ser_req), .route_in(route_in), .chain_in(chain_in));
	ltd_datapath dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .route_in(route_in), .route_out(route_out),
		.ctrl_out(ctrl_out), .chain_carry_in(chain_in[0]), .chain_shift_in(chain_in[1]),
		.chain_eq_in(chain_in[2]), .chain_lt_in(chain_in[3]),
		.chain_carry_out(chain_out[0]), .chain_shift_out(chain_out[1]),
		.chain_eq_out(chain_out[2]), .chain_lt_out(chain_out[3]));
	// ----------------------------------------
	// clock, timeout, helpers
	// ----------------------------------------
	always #25 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// idle cycle after each transfer keeps psel from being driven twice in one step
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	function automatic logic [31:0] exp_alu(int k, logic [7:0] x, logic [7:0] y, logic [7:0] o,
		logic s);
		case (k)
			0: return {24'h000000, x};
			1: return {24'h000000, x + 8'h01};
			2: return {24'h000000, x - 8'h01};
			3: return {24'h000000, x + y};
			4: return {24'h000000, x - y};
			5: return {24'h000000, x & y};
			6: return {24'h000000, x | y};
			7: return {24'h000000, x ^ y};
			8: return {24'h000000, x[3:0], x[7:4]};
			9: return {24'h000000, x | o};
			10: return {24'h000000, x[6:0], s};
			11: return {24'h000000, s, x[7:1]};
			default: return {24'h000000, {x[6:0], 1'b0} ^ ((x[7] ^ s) ? y : 8'h00)};
		endcase
	endfunction : exp_alu
	// pass into acc0 with swap, or-mask, shift left, shift right, crc step
	function automatic logic [15:0] cw_of(int k);
		case (k)
			8: return 16'h01C0;
			9: return 16'h0500;
			10: return 16'h0140;
			11: return 16'h0180;
			12: return 16'h1100;
			default: return 16'h0100 | 16'(k);
		endcase
	endfunction : cw_of
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, spare_req, ser_req} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		idx_req = 3'h0;
		void'($urandom(12));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, ltd_pkg::OFF_CFG, 32'h0);
		chk(r, ltd_pkg::CFG_RST);
		apb(1'b0, ltd_pkg::OFF_MASK, 32'h0);
		chk(r, ltd_pkg::MASK_RST);
		apb(1'b0, 8'h30, 32'h0);
		chk(r, 32'h0);
		chk({31'h0, e}, 32'h1);
		d = $urandom;
		apb(1'b1, ltd_pkg::OFF_CTRL, d);
		chk(ctrl_out, d[7:0]);
		apb(1'b1, ltd_pkg::OFF_CFG, 32'h71);
		for (int k = 0; k < 13; k++) begin
			a = $urandom;
			b = $urandom;
			m = 8'($urandom);
			s = 1'($urandom);
			cw = cw_of(k);
			apb(1'b1, ltd_pkg::OFF_MASK, {8'h00, m, 16'hFFFF});
			apb(1'b1, ltd_pkg::OFF_ACC0, {24'h0, a[7:0]});
			apb(1'b1, ltd_pkg::OFF_DAT0, {24'h0, b[7:0]});
			apb(1'b1, ltd_pkg::OFF_CRAM + 8'h04, {16'h0, cw});
			idx_req <= 3'h1;
			ser_req <= s;
			@(posedge pclk);
			idx_req <= 3'h0;
			repeat (3) @(posedge pclk);
			apb(1'b0, ltd_pkg::OFF_ACC0, 32'h0);
			chk(r, exp_alu(k, a[7:0], b[7:0], m, s));
		end
		// ----------------------------------------
		// time shared 16-bit add: low byte, then high byte with held carry
		// ----------------------------------------
		a = $urandom;
		b = $urandom;
		apb(1'b1, ltd_pkg::OFF_ACC0, {24'h0, a[7:0]});
		apb(1'b1, ltd_pkg::OFF_ACC1, {24'h0, a[15:8]});
		apb(1'b1, ltd_pkg::OFF_DAT0, {24'h0, b[7:0]});
		apb(1'b1, ltd_pkg::OFF_DAT1, {24'h0, b[15:8]});
		apb(1'b1, ltd_pkg::OFF_CRAM + 8'h04, 32'h00000103);
		apb(1'b1, ltd_pkg::OFF_CRAM + 8'h08, 32'h00000A1B);
		apb(1'b1, ltd_pkg::OFF_CFG, 32'h00000171);
		idx_req <= 3'h1;
		@(posedge pclk);
		idx_req <= 3'h2;
		@(posedge pclk);
		idx_req <= 3'h0;
		@(posedge pclk);
		c9 = {1'b0, a[7:0]} + {1'b0, b[7:0]};
		d = {16'h0, a[15:0]} + {16'h0, b[15:0]};
		chk(chain_out, {a[7:0] < b[7:0], a[7:0] == b[7:0], 1'b0, c9[8]});
		apb(1'b0, ltd_pkg::OFF_ACC0, 32'h0);
		first = r;
		apb(1'b0, ltd_pkg::OFF_ACC1, 32'h0);
		chk({r[7:0], first[7:0]}, {16'h0, d[15:0]});
		apb(1'b1, ltd_pkg::OFF_OSEL, 32'h00000FCB);
		spare_req <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(route_out[2:0], 3'h5);
		spare_req <= 1'b0;
		first = $urandom;
		apb(1'b1, ltd_pkg::OFF_FIFO0, {24'h0, first[7:0]});
		for (int i = 0; i < 4; i++) apb(1'b1, ltd_pkg::OFF_FIFO0, $urandom);
		repeat (2) @(posedge pclk);
		chk(route_out[1:0], 2'h2);
		apb(1'b0, ltd_pkg::OFF_FIFO0, 32'h0);
		chk(r, {24'h0, first[7:0]});
		apb(1'b1, ltd_pkg::OFF_SSEL, 32'h0000000F);
		apb(1'b1, ltd_pkg::OFF_MASK, 32'h0100FFFF);
		apb(1'b1, ltd_pkg::OFF_CFG, 32'h73);
		spare_req <= 1'b1;
		@(posedge pclk);
		spare_req <= 1'b0;
		repeat (3) @(posedge pclk);
		apb(1'b0, ltd_pkg::OFF_STAT, 32'h0);
		chk(r[0], 1'b1);
		apb(1'b1, ltd_pkg::OFF_STAT, 32'h000000FF);
		apb(1'b0, ltd_pkg::OFF_STAT, 32'h0);
		chk(r[0], 1'b0);
		tally_and_finish();
	end
endmodule : ltd_datapath_tb_top
